// ===== ivpr_defs.vh
`ifndef IVPR_DEFS_VH
`define IVPR_DEFS_VH

// source count and field widths
`define IVPR_NSRC          21
`define IVPR_IDX_W         5
`define IVPR_DATA_W        32

// register byte offsets
`define IVPR_OFS_FLAG      8'h00
`define IVPR_OFS_MASK      8'h04
`define IVPR_OFS_PRIO0     8'h08
`define IVPR_OFS_PRIO1     8'h0C
`define IVPR_OFS_LVCTRL    8'h10
`define IVPR_OFS_STATUS    8'h14
`define IVPR_OFS_CAUSE     8'h18

// reset values
`define IVPR_RST_MASK      21'h1FFFFF
`define IVPR_RST_PRIO      21'h1FFFFF
`define IVPR_RST_LVMODE    1'b0

// field positions
`define IVPR_LVMODE_BIT    1
`define IVPR_ST_PEND_BIT   24
`define IVPR_ST_SWI_BIT    25

// reset cause bits
`define IVPR_CAUSE_PIN     0
`define IVPR_CAUSE_PON     1
`define IVPR_CAUSE_LV      2
`define IVPR_CAUSE_WDG     3
`define IVPR_CAUSE_TRAP    4
`define IVPR_CAUSE_W       5

// opcodes and vectors
`define IVPR_ILLEGAL_OPCODE 8'hFF
`define IVPR_VEC_RESET     16'h0000
`define IVPR_VEC_SWI       16'h007E
`define IVPR_VEC_LVD       16'h0006
`define IVPR_VEC_TM2       16'h0030
`define IVPR_VEC_TM3       16'h0032
`define IVPR_VEC_AD        16'h0034
`define IVPR_VEC_RTC       16'h0036
`define IVPR_VEC_RTCI      16'h0038
`define IVPR_VEC_KR        16'h003A
`define IVPR_VEC_SER2      16'h003C
`define IVPR_VEC_P6        16'h003E
`define IVPR_VEC_TM4       16'h0042
`define IVPR_VEC_TM5       16'h0044
`define IVPR_VEC_TM6       16'h0046
`define IVPR_VEC_TM7       16'h0048
`define IVPR_VEC_SR2       16'h004A
`define IVPR_VEC_P8        16'h004E
`define IVPR_VEC_P9        16'h0050
`define IVPR_VEC_P10       16'h0052
`define IVPR_VEC_P11       16'h0054
`define IVPR_VEC_SRE2      16'h005C
`define IVPR_VEC_USB       16'h005E
`define IVPR_VEC_RSUM      16'h0060

`endif

// ===== ivpr_arbiter.v
`timescale 1ns/1ps
`include "ivpr_defs.vh"

module ivpr_arbiter (
    // requests and settings
    input  wire [`IVPR_NSRC-1:0]  req,
    input  wire [`IVPR_NSRC-1:0]  prio_b0,
    input  wire [`IVPR_NSRC-1:0]  prio_b1,
    input  wire                   global_en,
    input  wire [1:0]             isp,
    // winner
    output reg                    found,
    output reg  [`IVPR_IDX_W-1:0] idx
);

    integer    i;
    reg [2:0]  best;
    reg [1:0]  lvl;

    always @* begin
        found = 1'b0;
        idx   = {`IVPR_IDX_W{1'b0}};
        best  = 3'h4;
        lvl   = 2'h0;
        for (i = 0; i < `IVPR_NSRC; i = i + 1) begin
            lvl = {prio_b1[i], prio_b0[i]};
            if (req[i] && global_en && (isp == 2'h3 || lvl < isp)) begin
                if ({1'b0, lvl} < best) begin
                    best  = {1'b0, lvl};
                    idx   = i[`IVPR_IDX_W-1:0];
                    found = 1'b1;
                end
            end
        end
    end

endmodule // ivpr_arbiter

// ===== ivpr_reset_ctl.v
`timescale 1ns/1ps
`include "ivpr_defs.vh"

module ivpr_reset_ctl (
    // reset events
    input  wire                     reset_pin_event,
    input  wire                     power_on_clear_reset,
    input  wire                     low_voltage_detect,
    input  wire                     low_voltage_mode_select,
    input  wire                     watchdog_reset,
    // opcode watch
    input  wire                     opcode_fetch_valid,
    input  wire [7:0]               opcode_byte,
    input  wire                     debug_session_active,
    // result
    output reg  [`IVPR_CAUSE_W-1:0] cause
);

    always @* begin
        cause = {`IVPR_CAUSE_W{1'b0}};
        cause[`IVPR_CAUSE_PIN] = reset_pin_event;
        cause[`IVPR_CAUSE_PON] = power_on_clear_reset;
        // lv resets only when mode is 1
        cause[`IVPR_CAUSE_LV]  = low_voltage_detect & low_voltage_mode_select;
        cause[`IVPR_CAUSE_WDG] = watchdog_reset;
        cause[`IVPR_CAUSE_TRAP] = opcode_fetch_valid & ~debug_session_active
                                  & (opcode_byte == `IVPR_ILLEGAL_OPCODE);
    end

endmodule // ivpr_reset_ctl

// ===== ivpr_resolver.v
`timescale 1ns/1ps
`include "ivpr_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - simultaneous requests at one priority level: rank 0 first, 42 last
// - timer ch2/ch3 raise ranks 22/23
// - conversion end raises rank 24 at 0034H
// - rtc period or alarm: rank 25, 0036H
// - rtc interval: own rank 26, 0038H
// - key return: rank 27, 003AH
// - serial unit 2 roles share rank 28
// - pin 6 at 003EH, pins 8-11 004EH-0054H
// - timer ch4-7 ranks 31-34, 0042H-0048H
// - serial2 receive end: rank 35, 004AH
// - serial2 receive error: rank 40, 005CH
// - usb status 005EH, resume 0060H
// - break instruction vectors to 007EH
// - all resets and FFH trap use 0000H
// - no trap during debug emulation
// - low voltage resets only when mode 1
// - mode 0: low voltage is maskable request
// - vectors are two bytes, first 64K
// - break ignores global enable and priority
module ivpr_resolver (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // interrupt sources
    input  wire        timer_ch2_done_irq,
    input  wire        timer_ch3_done_irq,
    input  wire        conversion_done_irq,
    input  wire        rtc_period_alarm_irq,
    input  wire        rtc_interval_irq,
    input  wire        key_return_irq,
    input  wire        serial2_tx_done_irq,
    input  wire        clocked_serial2_done_irq,
    input  wire        twowire2_done_irq,
    input  wire        ext_pin6_irq,
    input  wire        timer_ch4_done_irq,
    input  wire        timer_ch5_done_irq,
    input  wire        timer_ch6_done_irq,
    input  wire        timer_ch7_done_irq,
    input  wire        serial2_rx_done_irq,
    input  wire        ext_pin8_irq,
    input  wire        ext_pin9_irq,
    input  wire        ext_pin10_irq,
    input  wire        ext_pin11_irq,
    input  wire        serial2_rx_error_irq,
    input  wire        usb_function_status_irq,
    input  wire        usb_resume_irq,
    // reset sources
    input  wire        reset_pin_event,
    input  wire        power_on_clear_reset,
    input  wire        low_voltage_detect,
    input  wire        watchdog_reset,
    // processor core
    input  wire        global_enable_flag,
    input  wire        in_service_level_bit0,
    input  wire        in_service_level_bit1,
    input  wire        break_instruction,
    input  wire        opcode_fetch_valid,
    input  wire [7:0]  opcode_byte,
    input  wire        debug_session_active,
    input  wire        int_ack,
    output reg         int_request,
    output reg  [15:0] int_vector,
    output reg         reset_request,
    output reg  [15:0] reset_vector
);

    ////////////////////////////////////////////////////////////////////////////
    // vector table

    // vectors are 16 bits, so every branch stays below 10000H
    function [15:0] vec_of;
        input [`IVPR_IDX_W-1:0] i;
        begin
            case (i)
                5'd0:    vec_of = `IVPR_VEC_LVD;
                5'd1:    vec_of = `IVPR_VEC_TM2;
                5'd2:    vec_of = `IVPR_VEC_TM3;
                5'd3:    vec_of = `IVPR_VEC_AD;
                5'd4:    vec_of = `IVPR_VEC_RTC;
                5'd5:    vec_of = `IVPR_VEC_RTCI;
                5'd6:    vec_of = `IVPR_VEC_KR;
                5'd7:    vec_of = `IVPR_VEC_SER2;
                5'd8:    vec_of = `IVPR_VEC_P6;
                5'd9:    vec_of = `IVPR_VEC_TM4;
                5'd10:   vec_of = `IVPR_VEC_TM5;
                5'd11:   vec_of = `IVPR_VEC_TM6;
                5'd12:   vec_of = `IVPR_VEC_TM7;
                5'd13:   vec_of = `IVPR_VEC_SR2;
                5'd14:   vec_of = `IVPR_VEC_P8;
                5'd15:   vec_of = `IVPR_VEC_P9;
                5'd16:   vec_of = `IVPR_VEC_P10;
                5'd17:   vec_of = `IVPR_VEC_P11;
                5'd18:   vec_of = `IVPR_VEC_SRE2;
                5'd19:   vec_of = `IVPR_VEC_USB;
                5'd20:   vec_of = `IVPR_VEC_RSUM;
                default: vec_of = `IVPR_VEC_RESET;
            endcase
        end
    endfunction

    function [`IVPR_NSRC-1:0] onehot;
        input [`IVPR_IDX_W-1:0] i;
        begin
            onehot = {{(`IVPR_NSRC-1){1'b0}}, 1'b1} << i;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers and wires

    reg  [`IVPR_NSRC-1:0]   flag_q;
    reg  [`IVPR_NSRC-1:0]   flag_d;
    reg  [`IVPR_NSRC-1:0]   mask_q;
    reg  [`IVPR_NSRC-1:0]   prio0_q;
    reg  [`IVPR_NSRC-1:0]   prio1_q;
    reg                     lvmode_q;
    reg  [`IVPR_CAUSE_W-1:0] cause_q;
    reg                     swi_q;
    reg                     sel_swi_q;
    reg  [`IVPR_IDX_W-1:0]  win_q;
    reg                     wr_pend_q;
    reg                     rd_pend_q;
    reg  [7:0]              addr_q;
    reg  [31:0]             rdata_d;
    wire [`IVPR_NSRC-1:0]   src_evt;
    wire [`IVPR_NSRC-1:0]   ack_clr;
    wire [`IVPR_NSRC-1:0]   eligible;
    wire [`IVPR_CAUSE_W-1:0] cause_evt;
    wire                    arb_found;
    wire [`IVPR_IDX_W-1:0]  arb_idx;
    wire                    swi_eff;
    wire                    addr_ph;
    wire                    lv_irq;

    ////////////////////////////////////////////////////////////////////////////
    // request events

    // with mode 0, low voltage becomes a maskable request
    assign lv_irq = low_voltage_detect & ~lvmode_q;

    // any serial2 role sets the one shared flag
    assign src_evt = {usb_resume_irq, usb_function_status_irq, serial2_rx_error_irq,
                      ext_pin11_irq, ext_pin10_irq, ext_pin9_irq, ext_pin8_irq,
                      serial2_rx_done_irq, timer_ch7_done_irq, timer_ch6_done_irq,
                      timer_ch5_done_irq, timer_ch4_done_irq, ext_pin6_irq,
                      serial2_tx_done_irq | clocked_serial2_done_irq | twowire2_done_irq,
                      key_return_irq, rtc_interval_irq, rtc_period_alarm_irq,
                      conversion_done_irq, timer_ch3_done_irq, timer_ch2_done_irq,
                      lv_irq};

    // the presented request is taken away in the ack cycle so it is not shown twice
    assign ack_clr  = (int_ack && int_request && !sel_swi_q) ? onehot(win_q)
                                                             : {`IVPR_NSRC{1'b0}};
    // only set and unmasked flags compete
    assign eligible = flag_q & ~ack_clr & ~mask_q;
    assign swi_eff  = swi_q & ~(int_ack & int_request & sel_swi_q);

    ivpr_arbiter u_arb (
        .req       (eligible),
        .prio_b0   (prio0_q),
        .prio_b1   (prio1_q),
        .global_en (global_enable_flag),
        .isp       ({in_service_level_bit1, in_service_level_bit0}),
        .found     (arb_found),
        .idx       (arb_idx)
    );

    ivpr_reset_ctl u_rst (
        .reset_pin_event         (reset_pin_event),
        .power_on_clear_reset    (power_on_clear_reset),
        .low_voltage_detect      (low_voltage_detect),
        .low_voltage_mode_select (lvmode_q),
        .watchdog_reset          (watchdog_reset),
        .opcode_fetch_valid      (opcode_fetch_valid),
        .opcode_byte             (opcode_byte),
        .debug_session_active    (debug_session_active),
        .cause                   (cause_evt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    assign addr_ph = hsel & htrans[1] & hready;

    always @* begin
        // set wins over software and ack clears
        flag_d = flag_q & ~ack_clr;
        if (wr_pend_q && addr_q == `IVPR_OFS_FLAG) begin
            flag_d = flag_d & ~hwdata[`IVPR_NSRC-1:0];
        end
        flag_d = flag_d | src_evt;
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        case (addr_q)
            `IVPR_OFS_FLAG:   rdata_d[`IVPR_NSRC-1:0] = flag_q;
            `IVPR_OFS_MASK:   rdata_d[`IVPR_NSRC-1:0] = mask_q;
            `IVPR_OFS_PRIO0:  rdata_d[`IVPR_NSRC-1:0] = prio0_q;
            `IVPR_OFS_PRIO1:  rdata_d[`IVPR_NSRC-1:0] = prio1_q;
            `IVPR_OFS_LVCTRL: rdata_d[`IVPR_LVMODE_BIT] = lvmode_q;
            `IVPR_OFS_STATUS: begin
                rdata_d[15:0]  = int_vector;
                rdata_d[20:16] = win_q;
                rdata_d[`IVPR_ST_PEND_BIT] = int_request;
                rdata_d[`IVPR_ST_SWI_BIT]  = swi_q;
            end
            `IVPR_OFS_CAUSE:  rdata_d[`IVPR_CAUSE_W-1:0] = cause_q;
            default:          rdata_d = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: writes without wait, reads with one wait for fresh data

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            hresp <= 1'b0;
            if (rd_pend_q) begin
                hrdata    <= rdata_d;
                hreadyout <= 1'b1;
                rd_pend_q <= 1'b0;
                wr_pend_q <= 1'b0;
            end else if (addr_ph) begin
                addr_q    <= {haddr[7:2], 2'b00};
                wr_pend_q <= hwrite;
                rd_pend_q <= ~hwrite;
                hreadyout <= hwrite;
            end else begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_q   <= {`IVPR_NSRC{1'b0}};
            mask_q   <= `IVPR_RST_MASK;
            prio0_q  <= `IVPR_RST_PRIO;
            prio1_q  <= `IVPR_RST_PRIO;
            lvmode_q <= `IVPR_RST_LVMODE;
            cause_q  <= {`IVPR_CAUSE_W{1'b0}};
            swi_q    <= 1'b0;
        end else begin
            flag_q <= flag_d;
            if (wr_pend_q) begin
                case (addr_q)
                    `IVPR_OFS_MASK:   mask_q   <= hwdata[`IVPR_NSRC-1:0];
                    `IVPR_OFS_PRIO0:  prio0_q  <= hwdata[`IVPR_NSRC-1:0];
                    `IVPR_OFS_PRIO1:  prio1_q  <= hwdata[`IVPR_NSRC-1:0];
                    `IVPR_OFS_LVCTRL: lvmode_q <= hwdata[`IVPR_LVMODE_BIT];
                    default:          lvmode_q <= lvmode_q;
                endcase
            end
            // cause bits: write 1 clears, a new event wins
            if (wr_pend_q && addr_q == `IVPR_OFS_CAUSE) begin
                cause_q <= (cause_q & ~hwdata[`IVPR_CAUSE_W-1:0]) | cause_evt;
            end else begin
                cause_q <= cause_q | cause_evt;
            end
            // break request waits for the core
            swi_q <= swi_eff | break_instruction;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core outputs

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_request   <= 1'b0;
            int_vector    <= `IVPR_VEC_RESET;
            sel_swi_q     <= 1'b0;
            win_q         <= {`IVPR_IDX_W{1'b0}};
            reset_request <= 1'b0;
            reset_vector  <= `IVPR_VEC_RESET;
        end else begin
            // every reset cause branches to 0000H
            reset_request <= |cause_evt;
            reset_vector  <= `IVPR_VEC_RESET;
            if (swi_eff) begin
                int_request <= 1'b1;
                int_vector  <= `IVPR_VEC_SWI;
                sel_swi_q   <= 1'b1;
            end else if (arb_found) begin
                int_request <= 1'b1;
                int_vector  <= vec_of(arb_idx);
                win_q       <= arb_idx;
                sel_swi_q   <= 1'b0;
            end else begin
                int_request <= 1'b0;
                sel_swi_q   <= 1'b0;
            end
        end
    end

endmodule // ivpr_resolver

// ===== ivpr_resolver_sva.sv
`timescale 1ns/1ps
module ivpr_sva_chk (
    // clock and reset
    input logic        clk_sys,
    input logic        rst_n,
    // bus
    input logic        hsel,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic        hready,
    input logic        hreadyout,
    input logic        hresp,
    // reset sources
    input logic        reset_pin_event,
    input logic        power_on_clear_reset,
    input logic        watchdog_reset,
    input logic        low_voltage_detect,
    input logic        opcode_fetch_valid,
    input logic [7:0]  opcode_byte,
    input logic        debug_session_active,
    // core side
    input logic        global_enable_flag,
    input logic        break_instruction,
    input logic        int_ack,
    input logic        int_request,
    input logic [15:0] int_vector,
    input logic        reset_request,
    input logic [15:0] reset_vector
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    sequence s_rd_taken;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_wr_taken;
        hsel && htrans[1] && hready && hwrite;
    endsequence
    sequence s_trap;
        opcode_fetch_valid && opcode_byte == 8'hFF;
    endsequence
    sequence s_cause;
        reset_pin_event || power_on_clear_reset || watchdog_reset;
    endsequence
    ////////////////////////////////////////
    chk_rd_wait: assert property (s_rd_taken |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not two cycles");
    chk_wr_nowait: assert property (s_wr_taken |=> hreadyout)
        else $error("write data phase stalled");
    chk_resp_okay: assert property (!hresp)
        else $error("bus response not okay");
    chk_rst_pulse: assert property (s_cause or (s_trap and !debug_session_active) |=> reset_request)
        else $error("reset cause gave no reset request");
    chk_rst_vector: assert property (reset_vector == 16'h0000)
        else $error("reset vector not zero");
    chk_trap_debug: assert property (s_trap and debug_session_active and !reset_pin_event
        && !power_on_clear_reset && !watchdog_reset && !low_voltage_detect |=> !reset_request)
        else $error("trap reset during debug session");
    chk_break_vec: assert property (break_instruction |-> ##2 int_request && int_vector == 16'h007E)
        else $error("break not presented at its vector");
    chk_vec_aligned: assert property (int_request |-> !int_vector[0] && int_vector <= 16'h007E)
        else $error("vector outside two-byte table");
    chk_ie_block: assert property (int_request && !$past(global_enable_flag) |-> int_vector == 16'h007E)
        else $error("maskable request while disabled");
    // a level source could legally re-present, so the bench keeps sources pulsed
    chk_ack_drops: assert property (int_request && int_ack && int_vector != 16'h007E
        |=> !int_request || int_vector != $past(int_vector))
        else $error("acknowledged request still presented");
endmodule // ivpr_sva_chk

bind ivpr_resolver ivpr_sva_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp),
    .reset_pin_event(reset_pin_event), .power_on_clear_reset(power_on_clear_reset),
    .watchdog_reset(watchdog_reset), .low_voltage_detect(low_voltage_detect),
    .opcode_fetch_valid(opcode_fetch_valid), .opcode_byte(opcode_byte),
    .debug_session_active(debug_session_active), .global_enable_flag(global_enable_flag),
    .break_instruction(break_instruction), .int_ack(int_ack), .int_request(int_request),
    .int_vector(int_vector), .reset_request(reset_request), .reset_vector(reset_vector));

// ===== ivpr_core_model.sv
`timescale 1ns/1ps
// core side: takes each presented request after a set wait
module ivpr_core_model (
    // clock and reset
    input  logic        clk_sys,
    input  logic        rst_n,
    // request side
    input  logic        int_request,
    input  logic [15:0] int_vector,
    input  logic [3:0]  ack_delay,
    // acknowledge and record
    output logic        int_ack,
    output logic [15:0] taken_vec,
    output int          taken_cnt
);
    logic [3:0] wait_q;
    logic       due;
    assign due = int_request && !int_ack && wait_q == ack_delay;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_ack <= 1'b0;
            wait_q <= 4'h0;
            taken_vec <= 16'h0000;
            taken_cnt <= 0;
        end else begin
            // a slow core lets a higher winner overtake before the ack
            int_ack <= due;
            wait_q <= (int_request && !int_ack && !due) ? wait_q + 4'h1 : 4'h0;
            if (int_ack && int_request) begin
                taken_vec <= int_vector;
                taken_cnt <= taken_cnt + 1;
            end
        end
    end
endmodule // ivpr_core_model

// ===== ivpr_resolver_bench.sv
`timescale 1ns/1ps
module ivpr_resolver_bench;
    logic        clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [1:0]  htrans = 2'h0, isp = 2'h3;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [22:0] src = 0;
    logic        pin = 0, pon = 0, wdg = 0, swi = 0, fetch = 0, dbg = 0, gie = 1;
    logic [7:0]  opc = 8'h00;
    logic        int_ack, int_request, reset_request;
    logic [15:0] int_vector, reset_vector, taken_vec;
    logic [3:0]  ack_delay = 4'h0;
    int          taken_cnt, num_errors = 0, n_checks = 0, cyc = 0;
    logic [15:0] vtab [0:22] = '{16'h0006, 16'h0030, 16'h0032, 16'h0034, 16'h0036, 16'h0038,
        16'h003A, 16'h003C, 16'h003E, 16'h0042, 16'h0044, 16'h0046, 16'h0048, 16'h004A,
        16'h004E, 16'h0050, 16'h0052, 16'h0054, 16'h005C, 16'h005E, 16'h0060, 16'h003C, 16'h003C};
    logic [7:0]  radr [0:7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
    logic [31:0] rexp [0:7] = '{0, 32'h1FFFFF, 32'h1FFFFF, 32'h1FFFFF, 0, 0, 0, 0};
    logic [31:0] cexp [0:4] = '{32'h1, 32'h2, 32'h8, 32'h10, 32'h4};
    always #10 clk_sys = ~clk_sys;
    assign hready = hreadyout;
    ivpr_resolver i_ivpr_resolver (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .low_voltage_detect(src[0]), .timer_ch2_done_irq(src[1]), .timer_ch3_done_irq(src[2]),
        .conversion_done_irq(src[3]), .rtc_period_alarm_irq(src[4]), .rtc_interval_irq(src[5]),
        .key_return_irq(src[6]), .serial2_tx_done_irq(src[7]), .ext_pin6_irq(src[8]),
        .timer_ch4_done_irq(src[9]), .timer_ch5_done_irq(src[10]),
        .timer_ch6_done_irq(src[11]), .timer_ch7_done_irq(src[12]),
        .serial2_rx_done_irq(src[13]), .ext_pin8_irq(src[14]), .ext_pin9_irq(src[15]),
        .ext_pin10_irq(src[16]), .ext_pin11_irq(src[17]), .serial2_rx_error_irq(src[18]),
        .usb_function_status_irq(src[19]), .usb_resume_irq(src[20]),
        .clocked_serial2_done_irq(src[21]), .twowire2_done_irq(src[22]),
        .reset_pin_event(pin), .power_on_clear_reset(pon), .watchdog_reset(wdg),
        .global_enable_flag(gie), .in_service_level_bit0(isp[0]), .in_service_level_bit1(isp[1]),
        .break_instruction(swi), .opcode_fetch_valid(fetch), .opcode_byte(opc),
        .debug_session_active(dbg), .int_ack(int_ack), .int_request(int_request),
        .int_vector(int_vector), .reset_request(reset_request), .reset_vector(reset_vector));
    ivpr_core_model i_ivpr_core_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .int_request(int_request), .int_vector(int_vector), .ack_delay(ack_delay),
        .int_ack(int_ack), .taken_vec(taken_vec), .taken_cnt(taken_cnt));
    ////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t %s", $time, msg);
        end
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task pulse(input logic [22:0] s);
        src <= s;
        @(posedge clk_sys);
        src <= 0;
    endtask
    task take(input logic [15:0] exp, input string msg);
        int n;
        n = taken_cnt;
        wait (taken_cnt != n);
        check(taken_vec, exp, msg);
        @(posedge clk_sys);
    endtask
    task quiet(input string msg);
        repeat (4) @(posedge clk_sys);
        check(int_request, 0, msg);
    endtask
    // cut a hang short; the whole run needs well under this
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            report_and_stop;
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            ahb(0, radr[k], 0);
            check(rd, rexp[k], "register reset value");
        end
        ahb(1, 8'h04, 0);
        for (int k = 0; k < 23; k++) begin
            pulse(23'h1 << k);
            take(vtab[k], "single source vector");
        end
        ack_delay <= 4'h3;
        pulse(23'h1FFFFF);
        for (int k = 0; k < 21; k++)
            take(vtab[k], "default order");
        ahb(1, 8'h08, 32'h0FFFFF);
        ahb(1, 8'h0C, 32'h0FFFFF);
        pulse(23'h100002);
        take(16'h0060, "level 0 first");
        take(16'h0030, "level 3 after");
        isp <= 2'h0;
        pulse(23'h100000);
        quiet("in-service level not beaten");
        isp <= 2'h3;
        take(16'h0060, "in-service released");
        ahb(1, 8'h04, 32'h2);
        pulse(23'h2);
        quiet("masked source");
        ahb(0, 8'h00, 0);
        check(rd, 32'h2, "flag held while masked");
        ahb(1, 8'h04, 0);
        take(16'h0030, "unmasked source");
        gie <= 1'b0;
        pulse(23'h4);
        swi <= 1'b1;
        @(posedge clk_sys);
        swi <= 1'b0;
        take(16'h007E, "break while disabled");
        quiet("maskable while disabled");
        gie <= 1'b1;
        take(16'h0032, "enabled again");
        ahb(1, 8'h10, 32'h2);
        for (int k = 0; k < 5; k++) begin
            {pin, pon, wdg, fetch} <= 4'h8 >> k;
            opc <= 8'hFF;
            src <= {22'h0, k == 4};
            @(posedge clk_sys);
            {pin, pon, wdg, fetch, src} <= 0;
            @(negedge clk_sys);
            check(reset_request, 1, "reset source");
            check(reset_vector, 0, "reset vector");
            ahb(0, 8'h18, 0);
            check(rd, cexp[k], "reset cause");
            ahb(1, 8'h18, 32'h1F);
        end
        ahb(1, 8'h10, 0);
        for (int k = 0; k < 3; k++) begin
            dbg <= k == 0;
            fetch <= k < 2;
            opc <= (k == 1) ? 8'hFE : 8'hFF;
            src <= {22'h0, k == 2};
            @(posedge clk_sys);
            {fetch, dbg, src} <= 0;
            @(negedge clk_sys);
            check(reset_request, 0, "no reset");
        end
        take(16'h0006, "low voltage as request");
        // a mid-run reset must drop a pending flag
        pulse(23'h2);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check(int_request, 0, "request cleared by reset");
        rst_n <= 1'b1;
        ahb(0, 8'h00, 0);
        check(rd, 0, "flag cleared by reset");
        report_and_stop;
    end
endmodule // ivpr_resolver_bench
